// ---- dv/dtcm_checker_assertions.sv ----
// Port-level checks of the dual timer block
`timescale 1ns/1ns
`include "dtcm_consts.vh"

module dtcm_checker
#(
	parameter MCYCLE_CLOCKS = 12
)
(
	input logic        clock_i,
	input logic        reset_i,
	input logic        psel_i,
	input logic        penable_i,
	input logic        pwrite_i,
	input logic [31:0] paddr_i,
	input logic [31:0] prdata_o,
	input logic        pready_o,
	input logic        pslverr_o,
	input logic        t1_baud_tick_o
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (reset_i);

	// ----------------------------------------
	// Register bus
	// ----------------------------------------
	property p_rdy_setup; psel_i && !penable_i |=> pready_o; endproperty
	a_rdy_setup: assert property (p_rdy_setup) else $error("no ready after setup");
	property p_rdy_one; pready_o |=> !pready_o; endproperty
	a_rdy_one: assert property (p_rdy_one) else $error("ready longer than one cycle");
	property p_rdy_cause; pready_o |-> $past(psel_i && !penable_i); endproperty
	a_rdy_cause: assert property (p_rdy_cause) else $error("ready without setup");
	property p_err_bad; pready_o && paddr_i[31:8] != 24'h0 |-> pslverr_o; endproperty
	a_err_bad: assert property (p_err_bad) else $error("unmapped access not refused");
	property p_err_ok; pready_o && paddr_i == {24'h0, `DTCM_ADDR_CONTROL} |-> !pslverr_o; endproperty
	a_err_ok: assert property (p_err_ok) else $error("control access refused");
	property p_err_quiet; !pready_o |-> !pslverr_o; endproperty
	a_err_quiet: assert property (p_err_quiet) else $error("error outside access");
	property p_err_data; pready_o && pslverr_o && !pwrite_i |-> prdata_o == 32'h0; endproperty
	a_err_data: assert property (p_err_data) else $error("refused read returned data");
	property p_upper; pready_o |-> prdata_o[31:8] == 24'h0; endproperty
	a_upper: assert property (p_upper) else $error("read data upper bits set");
	property p_ctl_low;
		pready_o && !pwrite_i && paddr_i == {24'h0, `DTCM_ADDR_CONTROL} |-> prdata_o[3:0] == 4'h0;
	endproperty
	a_ctl_low: assert property (p_ctl_low) else $error("control low bits set");

	// ----------------------------------------
	// Overflow pulse
	// ----------------------------------------
	// One tick per machine cycle at most, so a tick never lasts two clocks when a machine cycle is longer than one clock
	property p_tick; t1_baud_tick_o && MCYCLE_CLOCKS > 1 |=> !t1_baud_tick_o; endproperty
	a_tick: assert property (p_tick) else $error("baud tick too long");

	c_err: cover property (pready_o && pslverr_o);
	c_wr: cover property (pready_o && pwrite_i);
	c_tick: cover property (t1_baud_tick_o);
endmodule

bind dtcm_top dtcm_checker #(.MCYCLE_CLOCKS(MCYCLE_CLOCKS)) dtcm_checker_i
(
	.clock_i,
	.reset_i,
	.psel_i,
	.penable_i,
	.pwrite_i,
	.paddr_i,
	.prdata_o,
	.pready_o,
	.pslverr_o,
	.t1_baud_tick_o
);

// ---- dv/dtcm_pins_model.sv ----
// External count pin of timer 0 and gate pins of both timers
`timescale 1ns/1ns

module dtcm_pins_model
(
	input  logic clock_i,
	output logic t0_pin_o,
	output logic gate0_n_o,
	output logic t1_pin_o,
	output logic gate1_n_o
);
	initial
	begin
		t0_pin_o = 1'h1;
		gate0_n_o = 1'h1;
		t1_pin_o = 1'h1;
		gate1_n_o = 1'h1;
	end

	// Each level held well over a machine cycle so every sample sees it
	task automatic falls(input int n);
		repeat (n)
		begin
			repeat (8) @(posedge clock_i);
			t0_pin_o <= 1'h0;
			repeat (8) @(posedge clock_i);
			t0_pin_o <= 1'h1;
		end
	endtask

	task automatic gate(input logic v);
		@(posedge clock_i);
		gate0_n_o <= v;
	endtask

	task automatic gate1(input logic v);
		@(posedge clock_i);
		gate1_n_o <= v;
	endtask
endmodule

// ---- dv/dtcm_top_test.sv ----
// Register-level tests of the dual timer block
`timescale 1ns/1ns
`include "dtcm_consts.vh"

module dtcm_top_test;
	logic        clock_i = 1'h0;
	logic        reset_i = 1'h1;
	logic        psel_i = 1'h0;
	logic        penable_i = 1'h0;
	logic        pwrite_i = 1'h0;
	logic [31:0] paddr_i = 32'h0;
	logic [31:0] pwdata_i = 32'h0;
	logic [1:0]  vector_ack_i = 2'h0;
	wire  [31:0] prdata_o;
	wire         pready_o;
	wire         pslverr_o;
	wire         t0_pin;
	wire         gate0_n;
	wire         t1_pin;
	wire         gate1_n;
	wire         baud_tick;
	int          baud_ticks = 0;
	logic [31:0] rdata;
	logic        rerr;
	int          failures = 0;
	int          samples_checked = 0;

	dtcm_top #(.MCYCLE_CLOCKS(2)) dtcm_top_i
	(
		.clock_i,
		.reset_i,
		.psel_i,
		.penable_i,
		.pwrite_i,
		.paddr_i,
		.pwdata_i,
		.prdata_o,
		.pready_o,
		.pslverr_o,
		.t0_count_pin_i(t0_pin),
		.t1_count_pin_i(t1_pin),
		.external_gate_pin_n_i(gate0_n),
		.external_gate_pin_1_n_i(gate1_n),
		.vector_ack_i,
		.t1_baud_tick_o(baud_tick)
	);

	dtcm_pins_model dtcm_pins_model_i
	(
		.clock_i,
		.t0_pin_o(t0_pin),
		.gate0_n_o(gate0_n),
		.t1_pin_o(t1_pin),
		.gate1_n_o(gate1_n)
	);

	// Timer 1 overflows seen on the baud tick
	always @(posedge clock_i)
		if (baud_tick === 1'h1)
			baud_ticks <= baud_ticks + 1;

	always #(`DTCM_CLK_PERIOD_NS / 2) clock_i = ~clock_i;

	task automatic end_of_test;
		$display("Comparisons %0d, mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", s, exp, seen);
		end
	endtask

	// Request held until pready is seen high at a rising edge; only the watchdog ends a wait
	task automatic xfer(input logic [31:0] a, input logic w, input logic [7:0] d);
		psel_i <= 1'h1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= {24'h0, d};
		@(posedge clock_i);
		penable_i <= 1'h1;
		do
			@(posedge clock_i);
		while (pready_o !== 1'h1);
		rdata = prdata_o;
		rerr = pslverr_o;
		psel_i <= 1'h0;
		penable_i <= 1'h0;
		@(posedge clock_i);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		xfer(a, 1'h1, d);
	endtask

	task automatic rdc(input string s, input logic [7:0] a, input logic [31:0] exp);
		xfer(a, 1'h0, 8'h0);
		chk(s, rdata, exp);
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge clock_i);
	endtask

	initial
	begin
		repeat (8) @(posedge clock_i);
		reset_i <= 1'h0;
		rdc("ctl rst", `DTCM_ADDR_CONTROL, 32'h0);
		rdc("mode rst", `DTCM_ADDR_MODE, 32'h0);
		// Mode 1: carry into high byte, flag set then cleared by vector
		wr(`DTCM_ADDR_MODE, 8'h01);
		wr(`DTCM_ADDR_T0_LOW, 8'hfe);
		wr(`DTCM_ADDR_T0_HIGH, 8'hff);
		wr(`DTCM_ADDR_CONTROL, 8'h10);
		wt(20);
		rdc("t0 flag", `DTCM_ADDR_CONTROL, 32'h30);
		rdc("t0 high", `DTCM_ADDR_T0_HIGH, 32'h0);
		vector_ack_i <= 2'h1;
		@(posedge clock_i);
		vector_ack_i <= 2'h0;
		rdc("t0 ack", `DTCM_ADDR_CONTROL, 32'h10);
		wr(`DTCM_ADDR_CONTROL, 8'h00);
		// Mode 2 on timer 1: reload from a high byte that stays put
		wr(`DTCM_ADDR_MODE, 8'h20);
		wr(`DTCM_ADDR_T1_LOW, 8'hfe);
		wr(`DTCM_ADDR_T1_HIGH, 8'h80);
		wr(`DTCM_ADDR_CONTROL, 8'h40);
		wt(20);
		rdc("t1 flag", `DTCM_ADDR_CONTROL, 32'hc0);
		rdc("t1 high", `DTCM_ADDR_T1_HIGH, 32'h80);
		xfer(`DTCM_ADDR_T1_LOW, 1'h0, 8'h0);
		chk("t1 low", rdata & 32'h80, 32'h80);
		chk("baud one", baud_ticks, 32'h1);
		wr(`DTCM_ADDR_CONTROL, 8'h00);
		// Mode 0: five low bits prescale the high byte
		wr(`DTCM_ADDR_MODE, 8'h00);
		wr(`DTCM_ADDR_T0_LOW, 8'h1e);
		wr(`DTCM_ADDR_T0_HIGH, 8'h00);
		wr(`DTCM_ADDR_CONTROL, 8'h10);
		wt(20);
		rdc("m0 high", `DTCM_ADDR_T0_HIGH, 32'h1);
		wr(`DTCM_ADDR_CONTROL, 8'h00);
		// Counter function on the pin
		wr(`DTCM_ADDR_MODE, 8'h05);
		wr(`DTCM_ADDR_T0_LOW, 8'h55);
		wr(`DTCM_ADDR_CONTROL, 8'h10);
		rdc("run keep", `DTCM_ADDR_T0_LOW, 32'h55);
		dtcm_pins_model_i.falls(3);
		wt(10);
		rdc("edges", `DTCM_ADDR_T0_LOW, 32'h58);
		wr(`DTCM_ADDR_CONTROL, 8'h00);
		// Gate bit 3 with pin low stops timer 0
		wr(`DTCM_ADDR_MODE, 8'h09);
		dtcm_pins_model_i.gate(1'h0);
		wr(`DTCM_ADDR_T0_LOW, 8'h00);
		wr(`DTCM_ADDR_CONTROL, 8'h10);
		wt(20);
		rdc("gated", `DTCM_ADDR_T0_LOW, 32'h0);
		dtcm_pins_model_i.gate(1'h1);
		wt(20);
		xfer(`DTCM_ADDR_T0_LOW, 1'h0, 8'h0);
		chk("ungated", {31'h0, rdata != 32'h0}, 32'h1);
		wr(`DTCM_ADDR_CONTROL, 8'h00);
		// Split: timer 0 high uses timer 1 run and flag, timer 1 holds
		wr(`DTCM_ADDR_MODE, 8'h33);
		wr(`DTCM_ADDR_T1_LOW, 8'h11);
		wr(`DTCM_ADDR_T0_HIGH, 8'hfe);
		wr(`DTCM_ADDR_CONTROL, 8'h40);
		wt(20);
		rdc("split", `DTCM_ADDR_CONTROL, 32'hc0);
		xfer({24'h1, `DTCM_ADDR_CONTROL}, 1'h0, 8'h0);
		chk("high err", {31'h0, rerr}, 32'h1);
		chk("high data", rdata, 32'h0);
		rdc("t1 hold", `DTCM_ADDR_T1_LOW, 32'h11);
		wr(`DTCM_ADDR_CONTROL, 8'h00);
		// Timer 1 out of mode 3 under split: gated by its pin, then runs without its flag
		dtcm_pins_model_i.gate1(1'h0);
		wr(`DTCM_ADDR_MODE, 8'h93);
		wr(`DTCM_ADDR_T1_HIGH, 8'hff);
		wr(`DTCM_ADDR_T1_LOW, 8'hfe);
		wt(10);
		rdc("t1 gated", `DTCM_ADDR_T1_LOW, 32'hfe);
		dtcm_pins_model_i.gate1(1'h1);
		wt(20);
		rdc("t1 runs", `DTCM_ADDR_T1_HIGH, 32'h0);
		rdc("no t1 flag", `DTCM_ADDR_CONTROL, 32'h0);
		chk("baud two", baud_ticks, 32'h2);
		xfer(8'h95, 1'h0, 8'h0);
		chk("bad err", {31'h0, rerr}, 32'h1);
		chk("bad data", rdata, 32'h0);
		end_of_test();
	end

	initial
	begin
		repeat (5000) @(posedge clock_i);
		failures++;
		end_of_test();
	end
endmodule

// ---- hdl/dtcm_consts.vh ----
// Register offsets, field positions and timing constants of the dual timer block
`ifndef DTCM_CONSTS_VH
`define DTCM_CONSTS_VH

// ------------------------------------------------------------
// Register map (byte addresses)
// ------------------------------------------------------------
`define DTCM_ADDR_CONTROL   8'h88
`define DTCM_ADDR_MODE      8'h89
`define DTCM_ADDR_T0_LOW    8'h8a
`define DTCM_ADDR_T1_LOW    8'h8b
`define DTCM_ADDR_T0_HIGH   8'h8c
`define DTCM_ADDR_T1_HIGH   8'h8d
`define DTCM_ADDR_ACK       8'h90
`define DTCM_ADDR_WIDTH     8

// ------------------------------------------------------------
// Control register fields
// ------------------------------------------------------------
`define DTCM_CTL_T1_OVF     7
`define DTCM_CTL_T1_RUN     6
`define DTCM_CTL_T0_OVF     5
`define DTCM_CTL_T0_RUN     4
`define DTCM_CTL_RESET      8'h00

// ------------------------------------------------------------
// Mode register fields, per timer nibble
// ------------------------------------------------------------
`define DTCM_MODE_GATE      3
`define DTCM_MODE_CSEL      2
`define DTCM_MODE_RESET     8'h00
`define DTCM_MODE_13BIT     2'b00
`define DTCM_MODE_16BIT     2'b01
`define DTCM_MODE_RELOAD    2'b10
`define DTCM_MODE_SPLIT     2'b11
`define DTCM_PRESCALE_TOP   5'h1f

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define DTCM_CLK_PERIOD_NS  8
`define DTCM_MCYCLE_OSC     12

`endif

// ---- hdl/dtcm_counter.v ----
// One timer/counter: prescaled, 16-bit, auto-reload and split counting paths
`timescale 1ns/1ns
`include "dtcm_consts.vh"

module dtcm_counter
(
	input  wire       clock_i,
	input  wire       reset_i,
	input  wire [1:0] mode_i,
	input  wire       low_tick_i,
	input  wire       high_tick_i,
	input  wire       high_split_i,
	input  wire       low_wr_i,
	input  wire       high_wr_i,
	input  wire [7:0] wdata_i,
	output reg  [7:0] low_q,
	output reg  [7:0] high_q,
	output reg        low_ovf_o,
	output reg        high_ovf_o
);

	reg [7:0] low_d;
	reg [7:0] high_d;
	reg       low_ovf_d;
	reg       high_ovf_d;

	always @*
	begin
		low_d      = low_q;
		high_d     = high_q;
		low_ovf_d  = 1'b0;
		high_ovf_d = 1'b0;
		if (low_tick_i)
		begin
			case (mode_i)
				`DTCM_MODE_13BIT:
				begin
					// Only the low five bits form the prescaler; upper three are don't-care
					low_d[4:0] = low_q[4:0] + 5'h01; // [R1] [R2]
					if (low_q[4:0] == `DTCM_PRESCALE_TOP)
					begin
						high_d = high_q + 8'h01; // [R1]
						low_ovf_d = (high_q == 8'hff); // [R3]
					end
				end
				`DTCM_MODE_16BIT:
				begin
					low_d = low_q + 8'h01; // [R7]
					if (low_q == 8'hff)
					begin
						high_d = high_q + 8'h01; // [R7]
						low_ovf_d = (high_q == 8'hff); // [R3]
					end
				end
				`DTCM_MODE_RELOAD:
				begin
					if (low_q == 8'hff)
					begin
						low_d = high_q; // [R8] [R9]
						low_ovf_d = 1'b1; // [R8]
					end
					else
					begin
						low_d = low_q + 8'h01; // [R8]
					end
				end
				default:
				begin
					low_d = low_q + 8'h01; // [R11]
					low_ovf_d = (low_q == 8'hff); // [R11]
				end
			endcase
		end
		if (high_tick_i && high_split_i)
		begin
			high_d = high_q + 8'h01; // [R12]
			high_ovf_d = (high_q == 8'hff); // [R12]
		end
		// Software write beats a coincident count
		if (low_wr_i)
		begin
			low_d = wdata_i; // [R21]
		end
		if (high_wr_i)
		begin
			high_d = wdata_i; // [R21]
		end
	end

	always @(posedge clock_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			low_q      <= 8'h00;
			high_q     <= 8'h00;
			low_ovf_o  <= 1'b0;
			high_ovf_o <= 1'b0;
		end
		else
		begin
			low_q      <= low_d;
			high_q     <= high_d;
			low_ovf_o  <= low_ovf_d;
			high_ovf_o <= high_ovf_d;
		end
	end

endmodule

// ---- hdl/dtcm_top.v ----
// Dual timer/counter with APB register access
//
// Operation
// [R1] Mode 0: high byte behind divide-by-32 prescaler
// [R2] Mode 0: 8 high, 5 low bits
// [R3] Wrap to zero sets overflow flag
// [R4] Count when run and (no gate or pin high)
// [R5] Gate bits at mode bits 7 and 3
// [R6] Setting run leaves counts untouched
// [R7] Mode 1: full 16-bit cascade, no prescaler
// [R8] Mode 2: low byte reloads from high byte
// [R9] Reload never alters the high byte
// [R10] Timer 1 mode 3 holds its count
// [R11] Split timer 0 low byte: own controls
// [R12] Split high byte: timer 1 run, flag
// [R13] Timer 1 halts in mode 3 only
// [R14] Timer 1 keeps ticking, no own flag then
// [R15] Flags set on overflow, cleared on vector
// [R16] Control: flags 7,5, runs 6,4, resets zero
// [R17] Timer function counts each machine cycle
// [R18] Counter function counts sampled falling edges
// [R19] Counter-select: clear internal, set pin
// [R20] Mode bits choose one of four modes
// [R21] Software count write wins over increment
//
// Design decision made here: register access over APB.
`timescale 1ns/1ns
`include "dtcm_consts.vh"

module dtcm_top
#(
	parameter MCYCLE_CLOCKS = `DTCM_MCYCLE_OSC
)
(
	input  wire        clock_i,
	input  wire        reset_i,
	input  wire        psel_i,
	input  wire        penable_i,
	input  wire        pwrite_i,
	input  wire [31:0] paddr_i,
	input  wire [31:0] pwdata_i,
	output reg  [31:0] prdata_o,
	output reg         pready_o,
	output reg         pslverr_o,
	input  wire        t0_count_pin_i,
	input  wire        t1_count_pin_i,
	input  wire        external_gate_pin_n_i,
	input  wire        external_gate_pin_1_n_i,
	input  wire [1:0]  vector_ack_i,
	output reg         t1_baud_tick_o
);

	// ------------------------------------------------------------
	// Machine-cycle enable
	// ------------------------------------------------------------
	localparam CW = 4;

	reg [CW-1:0] div_q;
	reg          mcycle_q;

	always @(posedge clock_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			div_q    <= {CW{1'b0}};
			mcycle_q <= 1'b0;
		end
		else if (div_q == MCYCLE_CLOCKS[CW-1:0] - 4'h1)
		begin
			div_q    <= {CW{1'b0}};
			mcycle_q <= 1'b1; // [R17]
		end
		else
		begin
			div_q    <= div_q + 4'h1;
			mcycle_q <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Pin synchronisers and falling-edge sampling
	// ------------------------------------------------------------
	reg [3:0] pin_meta_q;
	reg [3:0] pin_sync_q;
	reg [1:0] pin_prev_q;
	wire [3:0] pin_raw = {external_gate_pin_1_n_i, external_gate_pin_n_i,
	                      t1_count_pin_i, t0_count_pin_i};

	always @(posedge clock_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			pin_meta_q <= 4'h0;
			pin_sync_q <= 4'h0;
			pin_prev_q <= 2'h0;
		end
		else
		begin
			pin_meta_q <= pin_raw;
			pin_sync_q <= pin_meta_q;
			if (mcycle_q)
			begin
				pin_prev_q <= pin_sync_q[1:0]; // [R18]
			end
		end
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	reg [7:0] ctl_q;
	reg [7:0] mode_q;

	wire [7:0] t0_low;
	wire [7:0] t0_high;
	wire [7:0] t1_low;
	wire [7:0] t1_high;
	wire [1:0] low_ovf;
	wire [1:0] high_ovf;

	wire       setup  = psel_i && !penable_i;
	wire       access = psel_i && penable_i && pready_o;
	wire       wr     = access && pwrite_i;
	wire [7:0] addr   = paddr_i[`DTCM_ADDR_WIDTH-1:0];
	wire       hit_hi = (paddr_i[31:`DTCM_ADDR_WIDTH] == 24'h000000);
	wire       t0_split = (mode_q[1:0] == `DTCM_MODE_SPLIT);

	wire [1:0] t_low_wr;
	wire [1:0] t_high_wr;
	assign t_low_wr  = {wr && hit_hi && addr == `DTCM_ADDR_T1_LOW,
	                    wr && hit_hi && addr == `DTCM_ADDR_T0_LOW};
	assign t_high_wr = {wr && hit_hi && addr == `DTCM_ADDR_T1_HIGH,
	                    wr && hit_hi && addr == `DTCM_ADDR_T0_HIGH};

	// ------------------------------------------------------------
	// Count enables per timer
	// ------------------------------------------------------------
	wire [1:0] low_tick;
	wire [1:0] run_bit = {ctl_q[`DTCM_CTL_T1_RUN], ctl_q[`DTCM_CTL_T0_RUN]};

	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1)
		begin : gen_tick
			wire [3:0] nib    = mode_q[4*g+3:4*g];
			wire       fall   = pin_prev_q[g] && !pin_sync_q[g]; // [R18]
			wire       src    = nib[`DTCM_MODE_CSEL] ? fall : 1'b1; // [R19]
			wire       gate   = !nib[`DTCM_MODE_GATE] || pin_sync_q[2+g]; // [R4] [R5]
			// Timer 1 in its own mode 3 behaves as if stopped
			wire       hold   = (g == 1) && (nib[1:0] == `DTCM_MODE_SPLIT); // [R10] [R13]
			// While timer 0 is split, timer 1 ignores its run bit (that is taken over)
			wire       runok  = ((g == 1) && t0_split) ? 1'b1 : run_bit[g]; // [R14]
			assign low_tick[g] = mcycle_q && src && gate && runok && !hold; // [R4]
		end
	endgenerate

	dtcm_counter u_t0
	(
		.clock_i      (clock_i),
		.reset_i      (reset_i),
		.mode_i       (mode_q[1:0]), // [R20]
		.low_tick_i   (low_tick[0]),
		.high_tick_i  (mcycle_q && ctl_q[`DTCM_CTL_T1_RUN]), // [R12]
		.high_split_i (t0_split),
		.low_wr_i     (t_low_wr[0]),
		.high_wr_i    (t_high_wr[0]),
		.wdata_i      (pwdata_i[7:0]),
		.low_q        (t0_low),
		.high_q       (t0_high),
		.low_ovf_o    (low_ovf[0]),
		.high_ovf_o   (high_ovf[0])
	);

	dtcm_counter u_t1
	(
		.clock_i      (clock_i),
		.reset_i      (reset_i),
		.mode_i       (mode_q[5:4]), // [R20]
		.low_tick_i   (low_tick[1]),
		.high_tick_i  (1'b0),
		.high_split_i (1'b0),
		.low_wr_i     (t_low_wr[1]),
		.high_wr_i    (t_high_wr[1]),
		.wdata_i      (pwdata_i[7:0]),
		.low_q        (t1_low),
		.high_q       (t1_high),
		.low_ovf_o    (low_ovf[1]),
		.high_ovf_o   (high_ovf[1])
	);

	// ------------------------------------------------------------
	// Control and mode registers
	// ------------------------------------------------------------
	wire t0_set = low_ovf[0]; // [R3]
	// Split high byte owns timer 1's flag; timer 1 then only feeds the baud tick
	wire t1_set = t0_split ? high_ovf[0] : low_ovf[1]; // [R12] [R14]
	wire ctl_wr = wr && hit_hi && addr == `DTCM_ADDR_CONTROL;
	wire ack_wr = wr && hit_hi && addr == `DTCM_ADDR_ACK;

	reg [7:0] ctl_d;

	always @*
	begin
		ctl_d = ctl_q;
		if (ctl_wr)
		begin
			// Run and flag bits written; counts are not touched here
			ctl_d = pwdata_i[7:0]; // [R6] [R16]
		end
		if (vector_ack_i[0] || (ack_wr && pwdata_i[0]))
		begin
			ctl_d[`DTCM_CTL_T0_OVF] = 1'b0; // [R15]
		end
		if (vector_ack_i[1] || (ack_wr && pwdata_i[1]))
		begin
			ctl_d[`DTCM_CTL_T1_OVF] = 1'b0; // [R15]
		end
		// Hardware set wins over any clear in the same cycle
		if (t0_set)
		begin
			ctl_d[`DTCM_CTL_T0_OVF] = 1'b1; // [R3] [R15]
		end
		if (t1_set)
		begin
			ctl_d[`DTCM_CTL_T1_OVF] = 1'b1; // [R3] [R15]
		end
		ctl_d[3:0] = 4'h0;
	end

	always @(posedge clock_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			ctl_q          <= `DTCM_CTL_RESET; // [R16]
			mode_q         <= `DTCM_MODE_RESET;
			t1_baud_tick_o <= 1'b0;
		end
		else
		begin
			ctl_q          <= ctl_d;
			t1_baud_tick_o <= low_ovf[1]; // [R14]
			if (wr && hit_hi && addr == `DTCM_ADDR_MODE)
			begin
				mode_q <= pwdata_i[7:0];
			end
		end
	end

	// ------------------------------------------------------------
	// APB slave: no wait states, read data registered
	// ------------------------------------------------------------
	reg [7:0] rd_d;
	reg       map_d;

	always @*
	begin
		map_d = hit_hi;
		case (addr)
			`DTCM_ADDR_CONTROL: rd_d = ctl_q;
			`DTCM_ADDR_MODE:    rd_d = mode_q;
			`DTCM_ADDR_T0_LOW:  rd_d = t0_low;
			`DTCM_ADDR_T1_LOW:  rd_d = t1_low;
			`DTCM_ADDR_T0_HIGH: rd_d = t0_high;
			`DTCM_ADDR_T1_HIGH: rd_d = t1_high;
			`DTCM_ADDR_ACK:     rd_d = 8'h00;
			default:
			begin
				rd_d  = 8'h00;
				map_d = 1'b0;
			end
		endcase
	end

	always @(posedge clock_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			pready_o  <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o  <= 32'h00000000;
		end
		else if (setup)
		begin
			pready_o  <= 1'b1;
			pslverr_o <= !map_d;
			// A refused read returns zero even when its low byte names a register
			prdata_o  <= {24'h000000, (pwrite_i || !map_d) ? 8'h00 : rd_d};
		end
		else
		begin
			pready_o  <= 1'b0;
			pslverr_o <= 1'b0;
		end
	end

endmodule
